// ### verilog/cwd_pkg.sv
package cwd_pkg;
    // word and field geometry
    localparam int CW_W = 24;
    localparam logic [7:0] CW_UPPER_ONES = 8'hFF;
    localparam int CW_UPPER_LSB = 16;
    // table-read index of each register
    localparam logic [2:0] IDX_CW1 = 3'h0;
    localparam logic [2:0] IDX_OSC_WORD = 3'h1;
    localparam logic [2:0] IDX_PROT_WORD = 3'h2;
    localparam logic [2:0] IDX_PART_ID = 3'h3;
    localparam logic [2:0] IDX_SI_REV = 3'h4;
    // flash word addresses relative to the top word
    localparam logic [23:0] CW_ADDR_STEP = 24'h000002;
    localparam logic [23:0] CFG_TOP_ADDR = 24'h02ABFE;
    // first word fields
    localparam int CW1_WDPS_LSB = 0;
    // second word fields
    localparam int OW_TWO_SPEED = 15;
    localparam int OW_PLL_PRE_LSB = 12;
    localparam int OW_PLL_OFF = 11;
    localparam int OW_OSC_SEL_LSB = 8;
    localparam int OW_MON_LSB = 6;
    localparam int OW_CLKOUT_FN = 5;
    localparam int OW_LOCK_ONCE = 4;
    localparam int OW_USB_REG_OFF = 3;
    localparam int OW_POSC_LSB = 0;
    // third word fields
    localparam int PW_END_SEL = 15;
    localparam int PW_CFG_PAGE = 14;
    localparam int PW_SEG_OFF = 13;
    localparam logic [23:0] PW_UNIMPL_ONES = 24'h001F00;
    localparam int PW_BOUND_LSB = 0;
    // id and revision word layout
    localparam int PID_FAM_LSB = 6;
    localparam logic [23:0] PID_UNIMPL_ONES = 24'hFFC000;
    localparam int REV_MAJ_LSB = 6;
    // program page: 512 instruction words, two address units each
    localparam int PAGE_ADDR_LSB = 10;
    localparam int PAGE_W = 8;
    // primary oscillator modes
    localparam logic [1:0] POSC_EXT = 2'h0;
    localparam logic [1:0] POSC_XT = 2'h1;
    localparam logic [1:0] POSC_HS = 2'h2;
    localparam logic [1:0] POSC_OFF = 2'h3;
    // start-up oscillator codes
    localparam logic [2:0] OSC_FRC = 3'h0;
    localparam logic [2:0] OSC_FRC_PLL = 3'h1;
    localparam logic [2:0] OSC_PRI = 3'h2;
    localparam logic [2:0] OSC_PRI_PLL = 3'h3;
    localparam logic [2:0] OSC_SEC = 3'h4;
    localparam logic [2:0] OSC_LOW_PWR_RC = 3'h5;
    localparam logic [2:0] OSC_RSVD = 3'h6;
    localparam logic [2:0] OSC_FRC_DIV = 3'h7;

    typedef enum logic [2:0] {
        CWD_SRC_FAST_RC,
        CWD_SRC_FAST_RC_POSTSCALE_PLL,
        CWD_SRC_PRIMARY,
        CWD_SRC_PRIMARY_PLL,
        CWD_SRC_SECONDARY,
        CWD_SRC_LOW_POWER_RC,
        CWD_SRC_RESERVED,
        CWD_SRC_FAST_RC_WITH_POSTSCALE
    } cwd_src_t;
endpackage : cwd_pkg

// ### verilog/cwd_flash_fetch.sv
`timescale 1ns/1ps
// one flash word read: holds the request until acknowledged, registers the data
module cwd_flash_fetch (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // command from the loader
    input wire logic start,
    input wire logic [cwd_pkg::CW_W-1:0] addr,
    output logic done,
    output logic [cwd_pkg::CW_W-1:0] word,
    // flash read port
    output logic flash_rd_req,
    output logic [cwd_pkg::CW_W-1:0] flash_addr,
    input wire logic [cwd_pkg::CW_W-1:0] flash_rd_data,
    input wire logic flash_rd_ack
);
    import cwd_pkg::*;

    logic next_req;
    logic [CW_W-1:0] next_addr;
    logic next_done;
    logic [CW_W-1:0] next_word;

    // request held until the flash answers
    always_comb begin
        next_req = flash_rd_req;
        next_addr = flash_addr;
        next_done = 1'b0;
        next_word = word;
        if (start && !flash_rd_req) begin
            next_req = 1'b1;
            next_addr = addr;
        end else if (flash_rd_req && flash_rd_ack) begin
            next_req = 1'b0;
            next_done = 1'b1;
            next_word = flash_rd_data;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flash_rd_req <= 1'b0;
            flash_addr <= '0;
            done <= 1'b0;
            word <= '1;
        end else begin
            flash_rd_req <= next_req;
            flash_addr <= next_addr;
            done <= next_done;
            word <= next_word;
        end
    end
endmodule : cwd_flash_fetch

// ### verilog/cwd_config_decode.sv
`timescale 1ns/1ps
module cwd_config_decode #(
    parameter logic [cwd_pkg::CW_W-1:0] TOP_ADDR = cwd_pkg::CFG_TOP_ADDR,
    parameter logic [cwd_pkg::PAGE_W-1:0] LAST_PAGE = 8'hAA,
    parameter logic [7:0] FAMILY_ID = 8'h5A,    // arbitrary value
    parameter logic [5:0] VARIANT_ID = 6'h2C,   // arbitrary value
    parameter logic [2:0] MAJOR_REV = 3'h1,     // arbitrary value
    parameter logic [2:0] MINOR_REV = 3'h2      // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic dev_rst,
    // flash read port
    output logic flash_rd_req,
    output logic [cwd_pkg::CW_W-1:0] flash_addr,
    input wire logic [cwd_pkg::CW_W-1:0] flash_rd_data,
    input wire logic flash_rd_ack,
    // table read port
    input wire logic tbl_rd_req,
    input wire logic [2:0] tbl_idx,
    output logic tbl_rd_valid,
    output logic [cwd_pkg::CW_W-1:0] tbl_rd_data,
    // load status
    output logic cfg_valid,
    // clock and oscillator settings
    output logic [15:0] wd_postscale_ratio,
    output logic two_speed_startup_en,
    output logic [3:0] usb_pll_prescale,
    output logic usb_pll_en,
    output cwd_pkg::cwd_src_t startup_osc_sel,
    output logic clk_switch_en,
    output logic fail_safe_mon_en,
    output logic [1:0] primary_osc_mode,
    output logic primary_osc_en,
    output logic clock_out_pin_en,
    output logic port_c_bit15_gpio,
    output logic usb_regulator_en,
    // pin-select lock
    input wire logic unlock_done,
    input wire logic lock_wr_req,
    input wire logic lock_wr_val,
    input wire logic pinsel_wr_req,
    output logic pinsel_wr_allow,
    output logic pinsel_lock,
    // program write protection check
    input wire logic [cwd_pkg::CW_W-1:0] prog_wr_addr,
    output logic prog_wr_protected
);
    import cwd_pkg::*;

    typedef enum logic [1:0] {
        CWD_ISSUE,
        CWD_WAIT,
        CWD_READY
    } cwd_state_t;

    // 3-bit prescaler code to divisor
    function automatic logic [3:0] pll_div(input logic [2:0] code);
        unique case (code)
            3'h0: pll_div = 4'h1;
            3'h1: pll_div = 4'h2;
            3'h2: pll_div = 4'h3;
            3'h3: pll_div = 4'h4;
            3'h4: pll_div = 4'h5;
            3'h5: pll_div = 4'h6;
            3'h6: pll_div = 4'hA;
            3'h7: pll_div = 4'hC;
        endcase
    endfunction : pll_div

    // page number of a program address
    function automatic logic [PAGE_W-1:0] page_of(input logic [CW_W-1:0] a);
        page_of = a[PAGE_ADDR_LSB +: PAGE_W];
    endfunction : page_of

    cwd_state_t state;
    cwd_state_t next_state;
    logic [1:0] word_cnt;
    logic [1:0] next_word_cnt;
    logic [CW_W-1:0] cw1;
    logic [CW_W-1:0] osc_word;
    logic [CW_W-1:0] prot_word;
    logic [CW_W-1:0] next_cw1;
    logic [CW_W-1:0] next_osc_word;
    logic [CW_W-1:0] next_prot_word;
    logic fetch_start;
    logic fetch_done;
    logic [CW_W-1:0] fetch_word;
    logic [CW_W-1:0] fetch_addr;

    cwd_flash_fetch u_fetch (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(fetch_start),
        .addr(fetch_addr),
        .done(fetch_done),
        .word(fetch_word),
        .flash_rd_req(flash_rd_req),
        .flash_addr(flash_addr),
        .flash_rd_data(flash_rd_data),
        .flash_rd_ack(flash_rd_ack)
    );

    // word n sits n steps below the top word
    always_comb begin
        unique case (word_cnt)
            2'h0: fetch_addr = TOP_ADDR;
            2'h1: fetch_addr = TOP_ADDR - CW_ADDR_STEP;
            default: fetch_addr = TOP_ADDR - CW_ADDR_STEP - CW_ADDR_STEP;
        endcase
    end

    // reload sequencer: three words after every reset
    always_comb begin
        next_state = state;
        next_word_cnt = word_cnt;
        next_cw1 = cw1;
        next_osc_word = osc_word;
        next_prot_word = prot_word;
        fetch_start = 1'b0;
        if (dev_rst) begin
            next_state = CWD_ISSUE;
            next_word_cnt = 2'h0;
        end else begin
            unique case (state)
                CWD_ISSUE: begin
                    if (!flash_rd_req && !fetch_done) begin
                        fetch_start = 1'b1;
                        next_state = CWD_WAIT;
                    end else if (flash_rd_req && flash_addr == fetch_addr) begin   // fetch already pending for this word
                        next_state = CWD_WAIT;
                    end
                end
                CWD_WAIT: begin
                    if (fetch_done) begin
                        // stored bits kept raw: programmed reads 0
                        unique case (word_cnt)
                            2'h0: next_cw1 = fetch_word;
                            2'h1: next_osc_word = fetch_word;
                            default: next_prot_word = fetch_word;
                        endcase
                        if (word_cnt == 2'h2) begin
                            next_state = CWD_READY;
                        end else begin
                            next_word_cnt = word_cnt + 2'h1;
                            next_state = CWD_ISSUE;
                        end
                    end
                end
                CWD_READY: begin
                    next_state = CWD_READY;
                end
            endcase
        end
    end

    // sequencer and configuration registers, unprogrammed at reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= CWD_ISSUE;
            word_cnt <= 2'h0;
            cw1 <= '1;
            osc_word <= '1;
            prot_word <= '1;
        end else begin
            state <= next_state;
            word_cnt <= next_word_cnt;
            cw1 <= next_cw1;
            osc_word <= next_osc_word;
            prot_word <= next_prot_word;
        end
    end

    // decoded settings, held while loading and between reloads
    logic [15:0] next_wd_ratio;
    logic next_two_speed;
    logic [3:0] next_pll_pre;
    logic next_pll_en;
    cwd_src_t next_osc_sel;
    logic next_sw_en;
    logic next_fs_en;
    logic [1:0] next_posc;
    logic next_posc_en;
    logic next_clkout;
    logic next_gpio;
    logic next_ureg_en;
    logic next_valid;
    logic clkout_owned;

    always_comb begin
        next_valid = (state == CWD_READY) && !dev_rst;
        clkout_owned = (osc_word[OW_POSC_LSB +: 2] == POSC_OFF) ||
                       (osc_word[OW_POSC_LSB +: 2] == POSC_EXT);
        next_wd_ratio = 16'h0001 << cw1[CW1_WDPS_LSB +: 4];
        next_two_speed = osc_word[OW_TWO_SPEED];
        next_pll_pre = pll_div(osc_word[OW_PLL_PRE_LSB +: 3]);
        next_pll_en = !osc_word[OW_PLL_OFF];
        next_osc_sel = cwd_src_t'(osc_word[OW_OSC_SEL_LSB +: 3]);
        next_sw_en = !osc_word[OW_MON_LSB + 1];
        next_fs_en = (osc_word[OW_MON_LSB +: 2] == 2'h0);
        next_posc = osc_word[OW_POSC_LSB +: 2];
        next_posc_en = (osc_word[OW_POSC_LSB +: 2] != POSC_OFF);
        next_clkout = clkout_owned && osc_word[OW_CLKOUT_FN];
        next_gpio = clkout_owned && !osc_word[OW_CLKOUT_FN];
        next_ureg_en = !osc_word[OW_USB_REG_OFF];
    end

    // settings update only when a load has finished
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_valid <= 1'b0;
            wd_postscale_ratio <= 16'h8000;
            two_speed_startup_en <= 1'b1;
            usb_pll_prescale <= 4'hC;
            usb_pll_en <= 1'b0;
            startup_osc_sel <= CWD_SRC_FAST_RC_WITH_POSTSCALE;
            clk_switch_en <= 1'b0;
            fail_safe_mon_en <= 1'b0;
            primary_osc_mode <= POSC_OFF;
            primary_osc_en <= 1'b0;
            clock_out_pin_en <= 1'b1;
            port_c_bit15_gpio <= 1'b0;
            usb_regulator_en <= 1'b0;
        end else begin
            cfg_valid <= next_valid;
            if (next_valid) begin
                wd_postscale_ratio <= next_wd_ratio;
                two_speed_startup_en <= next_two_speed;
                usb_pll_prescale <= next_pll_pre;
                usb_pll_en <= next_pll_en;
                startup_osc_sel <= next_osc_sel;
                clk_switch_en <= next_sw_en;
                fail_safe_mon_en <= next_fs_en;
                primary_osc_mode <= next_posc;
                primary_osc_en <= next_posc_en;
                clock_out_pin_en <= next_clkout;
                port_c_bit15_gpio <= next_gpio;
                usb_regulator_en <= next_ureg_en;
            end
        end
    end

    // pin-select lock policy
    logic next_lock;

    always_comb begin
        next_lock = pinsel_lock;
        if (dev_rst) begin
            next_lock = 1'b0;
        end else if (lock_wr_req && unlock_done) begin
            if (lock_wr_val) begin
                next_lock = 1'b1;
            end else if (!osc_word[OW_LOCK_ONCE]) begin
                next_lock = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinsel_lock <= 1'b0;
        end else begin
            pinsel_lock <= next_lock;
        end
    end

    // pin-select writes blocked once locked
    assign pinsel_wr_allow = pinsel_wr_req && !pinsel_lock;

    // segmented write-protection check
    logic [PAGE_W-1:0] wr_page;
    logic [PAGE_W-1:0] bound_page;
    logic in_segment;
    logic in_cfg_page;

    always_comb begin
        wr_page = page_of(prog_wr_addr);
        bound_page = prot_word[PW_BOUND_LSB +: PAGE_W];
        if (prot_word[PW_END_SEL]) begin
            in_segment = (wr_page <= bound_page);
        end else begin
            in_segment = (wr_page >= bound_page);
        end
        in_cfg_page = !prot_word[PW_CFG_PAGE] && (wr_page >= LAST_PAGE);
    end

    assign prog_wr_protected = !prot_word[PW_SEG_OFF] && (in_segment || in_cfg_page);

    // table reads, answered one cycle later
    logic [CW_W-1:0] next_tbl_data;

    always_comb begin
        unique case (tbl_idx)
            IDX_CW1: next_tbl_data = {CW_UPPER_ONES, cw1[CW_UPPER_LSB-1:0]};
            IDX_OSC_WORD: next_tbl_data = {CW_UPPER_ONES, osc_word[CW_UPPER_LSB-1:0]};
            IDX_PROT_WORD: next_tbl_data = {CW_UPPER_ONES, prot_word[CW_UPPER_LSB-1:0]} | PW_UNIMPL_ONES;
            IDX_PART_ID: next_tbl_data = PID_UNIMPL_ONES | {10'h000, FAMILY_ID, VARIANT_ID};
            IDX_SI_REV: next_tbl_data = {15'h0000, MAJOR_REV, 3'h0, MINOR_REV};
            default: next_tbl_data = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tbl_rd_valid <= 1'b0;
            tbl_rd_data <= '0;
        end else begin
            tbl_rd_valid <= tbl_rd_req;
            if (tbl_rd_req) begin
                tbl_rd_data <= next_tbl_data;
            end
        end
    end
endmodule : cwd_config_decode

// ### dv/cwd_asserts.sv
`timescale 1ns/1ps
// port relations of the configuration decoder
module cwd_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic dev_rst,
    // flash port
    input wire logic flash_rd_req,
    input wire logic flash_rd_ack,
    // table read and load status
    input wire logic tbl_rd_req,
    input wire logic tbl_rd_valid,
    input wire logic cfg_valid,
    // settings
    input wire logic [15:0] wd_postscale_ratio,
    input wire logic [3:0] usb_pll_prescale,
    input wire logic clk_switch_en,
    input wire logic fail_safe_mon_en,
    input wire logic [1:0] primary_osc_mode,
    input wire logic primary_osc_en,
    input wire logic clock_out_pin_en,
    input wire logic port_c_bit15_gpio,
    // pin-select lock
    input wire logic unlock_done,
    input wire logic lock_wr_req,
    input wire logic lock_wr_val,
    input wire logic pinsel_wr_req,
    input wire logic pinsel_wr_allow,
    input wire logic pinsel_lock
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // steps of a flash fetch and of a lock write
    sequence s_waiting;
        flash_rd_req && !flash_rd_ack && !dev_rst;
    endsequence
    sequence s_taken;
        flash_rd_req && flash_rd_ack && !dev_rst;
    endsequence
    sequence s_unlocked_wr;
        lock_wr_req && unlock_done && !dev_rst;
    endsequence

    a_fetch_holds: assert property (s_waiting |=> flash_rd_req)
        else $error("flash request dropped before ack");
    a_fetch_gap: assert property (s_taken |=> !flash_rd_req [*2])
        else $error("flash request too soon after ack");
    a_reload_clears: assert property (dev_rst |=> !cfg_valid && !pinsel_lock)
        else $error("device reset did not restart load");
    a_table_answer: assert property (tbl_rd_req |=> tbl_rd_valid)
        else $error("table read not answered");
    a_table_pulse: assert property (!tbl_rd_req |=> !tbl_rd_valid)
        else $error("table valid without request");
    a_ratio_onehot: assert property ($onehot(wd_postscale_ratio))
        else $error("postscale ratio not a power of two");
    a_prescale_legal: assert property (usb_pll_prescale inside {1, 2, 3, 4, 5, 6, 10, 12})
        else $error("prescale divisor outside table");
    a_monitor_needs_switch: assert property (fail_safe_mon_en |-> clk_switch_en)
        else $error("monitor on with switching off");
    a_posc_mode_en: assert property (primary_osc_en == (primary_osc_mode != 2'h3))
        else $error("primary enable disagrees with mode");
    a_clkout_ignored: assert property (primary_osc_mode inside {1, 2} |-> !clock_out_pin_en && !port_c_bit15_gpio)
        else $error("clock-out function active in crystal mode");
    a_clkout_applies: assert property (primary_osc_mode inside {0, 3} |-> clock_out_pin_en ^ port_c_bit15_gpio)
        else $error("clock-out pin function not exclusive");
    a_lock_sets: assert property (s_unlocked_wr ##0 lock_wr_val |=> pinsel_lock)
        else $error("unlocked lock write did not set lock");
    a_lock_needs_unlock: assert property (!unlock_done && !dev_rst |=> $stable(pinsel_lock))
        else $error("lock changed without unlock");
    a_write_gate: assert property (pinsel_wr_allow == (pinsel_wr_req && !pinsel_lock))
        else $error("pin-select write gate wrong");
    a_settings_frozen: assert property (cfg_valid && $past(cfg_valid) |->
        $stable(wd_postscale_ratio) && $stable(primary_osc_mode) && $stable(usb_pll_prescale))
        else $error("settings changed between loads");
endmodule : cwd_asserts

bind cwd_config_decode cwd_asserts u_chk (
    .ref_clk, .nrst, .dev_rst, .flash_rd_req, .flash_rd_ack, .tbl_rd_req, .tbl_rd_valid, .cfg_valid,
    .wd_postscale_ratio, .usb_pll_prescale, .clk_switch_en, .fail_safe_mon_en, .primary_osc_mode,
    .primary_osc_en, .clock_out_pin_en, .port_c_bit15_gpio, .unlock_done, .lock_wr_req, .lock_wr_val,
    .pinsel_wr_req, .pinsel_wr_allow, .pinsel_lock
);

// ### dv/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the configuration word decoder
module tb_top;
    import cwd_pkg::*;
    localparam logic [7:0] LAST = 8'hAA;
    localparam logic [7:0] FAM = 8'h3C; // arbitrary value
    localparam logic [5:0] VARI = 6'h15; // arbitrary value
    localparam logic [2:0] MAJ = 3'h5; // arbitrary value
    localparam logic [2:0] MIN = 3'h6; // arbitrary value
    logic ref_clk, nrst, dev_rst, flash_rd_req, flash_rd_ack, tbl_rd_req, tbl_rd_valid, cfg_valid;
    logic [23:0] flash_addr, flash_rd_data, tbl_rd_data, prog_wr_addr;
    logic [2:0] tbl_idx;
    logic [15:0] wd_postscale_ratio;
    logic [3:0] usb_pll_prescale;
    logic [1:0] primary_osc_mode;
    cwd_src_t startup_osc_sel;
    logic two_speed_startup_en, usb_pll_en, clk_switch_en, fail_safe_mon_en, primary_osc_en;
    logic clock_out_pin_en, port_c_bit15_gpio, usb_regulator_en, unlock_done, lock_wr_req, lock_wr_val;
    logic pinsel_wr_req, pinsel_wr_allow, pinsel_lock, prog_wr_protected;
    logic [16:0] got_set;
    int miscompares, checked;

    cwd_config_decode #(.LAST_PAGE(LAST), .FAMILY_ID(FAM), .VARIANT_ID(VARI), .MAJOR_REV(MAJ),
        .MINOR_REV(MIN)) dut (
        .ref_clk, .nrst, .dev_rst, .flash_rd_req, .flash_addr, .flash_rd_data, .flash_rd_ack,
        .tbl_rd_req, .tbl_idx, .tbl_rd_valid, .tbl_rd_data, .cfg_valid, .wd_postscale_ratio,
        .two_speed_startup_en, .usb_pll_prescale, .usb_pll_en, .startup_osc_sel, .clk_switch_en,
        .fail_safe_mon_en, .primary_osc_mode, .primary_osc_en, .clock_out_pin_en, .port_c_bit15_gpio,
        .usb_regulator_en, .unlock_done, .lock_wr_req, .lock_wr_val, .pinsel_wr_req, .pinsel_wr_allow,
        .pinsel_lock, .prog_wr_addr, .prog_wr_protected
    );

    // decoded settings gathered for one comparison
    assign got_set = {two_speed_startup_en, usb_pll_prescale, usb_pll_en, startup_osc_sel, clk_switch_en,
        fail_safe_mon_en, clock_out_pin_en, port_c_bit15_gpio, primary_osc_mode, primary_osc_en, usb_regulator_en};

    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // bounded wait for a fetch request or for load completion
    task automatic wait_hi(input bit for_valid);
        int n;
        n = 0;
        while ((for_valid ? cfg_valid : flash_rd_req) !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        if ((for_valid ? cfg_valid : flash_rd_req) !== 1'b1) begin
            miscompares++;
            complete_run;
        end
    endtask : wait_hi

    // answer one flash fetch, then scramble the released data lines
    task automatic serve(input logic [23:0] addr, input logic [23:0] w);
        wait_hi(1'b0);
        cmp("flash_addr", addr, flash_addr);
        flash_rd_data = w;
        flash_rd_ack = 1'b1;
        @(negedge ref_clk);
        flash_rd_ack = 1'b0;
        flash_rd_data = ~w;
    endtask : serve

    task automatic load(input logic [23:0] w1, input logic [23:0] w2, input logic [23:0] w3);
        @(negedge ref_clk);
        dev_rst = 1'b1;
        @(negedge ref_clk);
        dev_rst = 1'b0;
        serve(CFG_TOP_ADDR, w1);
        serve(CFG_TOP_ADDR - CW_ADDR_STEP, w2);
        serve(CFG_TOP_ADDR - (CW_ADDR_STEP << 1), w3);
        wait_hi(1'b1);
    endtask : load

    task automatic rd(input logic [2:0] idx, input logic [23:0] exp, input string what);
        tbl_idx = idx;
        tbl_rd_req = 1'b1;
        @(negedge ref_clk);
        tbl_rd_req = 1'b0;
        cmp("tbl_rd_valid", 24'h000001, {23'h0, tbl_rd_valid});
        cmp(what, exp, tbl_rd_data);
        @(negedge ref_clk);
        cmp("tbl_rd_valid_drop", 24'h000000, {23'h0, tbl_rd_valid});
    endtask : rd

    task automatic lk(input logic u, input logic v);
        unlock_done = u;
        lock_wr_req = 1'b1;
        lock_wr_val = v;
        @(negedge ref_clk);
        lock_wr_req = 1'b0;
        unlock_done = 1'b0;
        @(negedge ref_clk);
    endtask : lk

    function automatic logic [16:0] exp_set(input logic [23:0] w);
        logic [3:0] div [8];
        logic on;
        div = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
        on = (w[1:0] == 2'h0) || (w[1:0] == 2'h3);
        return {w[15], div[w[14:12]], !w[11], w[10:8], !w[7], w[7:6] == 2'h0, on && w[5], on && !w[5],
            w[1:0], w[1:0] != 2'h3, !w[3]};
    endfunction : exp_set

    function automatic logic prot(input logic [23:0] a, input logic [23:0] w3);
        logic [7:0] pg;
        pg = a[17:10];
        if (w3[13])
            return 1'b0;
        return (w3[15] ? pg <= w3[7:0] : pg >= w3[7:0]) || (!w3[14] && pg >= LAST);
    endfunction : prot

    // main sequence
    initial begin
        logic [23:0] w1, w2, w3;
        logic [23:0] pa [5];
        miscompares = 0;
        checked = 0;
        {nrst, dev_rst, flash_rd_ack, tbl_rd_req, unlock_done, lock_wr_req, lock_wr_val, pinsel_wr_req} = '0;
        {flash_rd_data, prog_wr_addr, tbl_idx} = '0;
        repeat (8) @(negedge ref_clk);
        cmp("reset_ratio", 24'h008000, {8'h0, wd_postscale_ratio});
        cmp("reset_settings", {7'h0, exp_set(24'hFFFFFF)}, {7'h0, got_set});
        cmp("reset_req", 24'h0, {23'h0, flash_rd_req});
        nrst = 1'b1;
        // device reset with a fetch outstanding: the stale word must be dropped
        serve(CFG_TOP_ADDR, 24'h000000);
        wait_hi(1'b0);
        dev_rst = 1'b1;
        @(negedge ref_clk);
        dev_rst = 1'b0;
        serve(CFG_TOP_ADDR - CW_ADDR_STEP, 24'h000000);
        for (int k = 0; k < 16; k++) begin
            w1 = {12'hFFF, 8'hFF, k[3:0]};
            w2 = {8'h00, k[0], k[2:0], k[1], k[2:0] + 3'h3, k[1:0], k[1], k[2], k[0], 1'b1, k[3:2]};
            w3 = {8'h5A, k[0], k[1], k[2], 5'h00, 8'(k * 17)};
            load(w1, w2, w3);
            cmp("ratio", {8'h0, 16'h1 << k}, {8'h0, wd_postscale_ratio});
            cmp("settings", {7'h0, exp_set(w2)}, {7'h0, got_set});
            rd(IDX_CW1, w1, "word_one");
            rd(IDX_OSC_WORD, {8'hFF, w2[15:0]}, "word_two");
            rd(IDX_PROT_WORD, {8'hFF, w3[15:13], 5'h1F, w3[7:0]}, "word_three");
            rd(IDX_PART_ID, {10'h3FF, FAM, VARI}, "ident");
            rd(IDX_SI_REV, {15'h0, MAJ, 3'h0, MIN}, "revision");
            rd(3'h5, 24'h0, "unmapped");
            pinsel_wr_req = 1'b1;
            lk(1'b0, 1'b1);
            cmp("lock_no_unlock", 24'h000001, {22'h0, pinsel_lock, pinsel_wr_allow});
            lk(1'b1, 1'b1);
            cmp("lock_set", 24'h000002, {22'h0, pinsel_lock, pinsel_wr_allow});
            pinsel_wr_req = 1'b0;
            lk(1'b1, 1'b0);
            cmp("lock_clear", {23'h0, w2[4]}, {23'h0, pinsel_lock});
            pa[0] = {6'h0, w3[7:0], 10'h000};
            pa[1] = {6'h0, w3[7:0], 10'h3FF};
            pa[2] = {6'h0, w3[7:0] - 8'h1, 10'h3FF};
            pa[3] = {6'h0, w3[7:0] + 8'h1, 10'h000};
            pa[4] = {6'h0, LAST, 10'h000};
            for (int j = 0; j < 5; j++) begin
                prog_wr_addr = pa[j];
                @(negedge ref_clk);
                cmp("protect", {23'h0, prot(pa[j], w3)}, {23'h0, prog_wr_protected});
            end
        end
        complete_run;
    end
endmodule : tb_top
